//--- verilog/bus_mgmt_swap_compare_value_swap.sv
// APB register group giving software compare-swap access to bus-management resources
//
// Overview of operation
// - Software reaches the resources only by compare-swap via these three registers.
// - Swap data word at 0Ch is stored into the resource only on a match.
// - Compare word at 10h is checked against the selected resource's contents.
// - Control bit 31 at 14h is set when a compare-swap has finished.
// - A write to the control register clears the completion flag unless a swap completes in that cycle.
// - Control bits 1-0 select bus manager, bandwidth, channels high, channels low.
// - Control bits 30-2 are reserved and always read as zero.
`timescale 1ns/1ps
`default_nettype none

module bus_mgmt_swap_compare_value_swap (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bus_mgmt_csr_pkg::ADDR_W-1:0] paddr,
    input wire logic [bus_mgmt_csr_pkg::DATA_W-1:0] pwdata,
    output logic [bus_mgmt_csr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import bus_mgmt_csr_pkg::*;

    // Bus phase qualifiers
    logic setupPhase;
    logic accessPhase;
    logic writeAccess;

    // Per-register write strobes
    logic wrData;
    logic wrCompare;
    logic wrControl;
    logic wrIrqStatus;
    logic wrIrqMask;

    // Software-visible state
    logic [31:0] swapData_q, swapData_d;
    logic [31:0] swapCompare_q, swapCompare_d;
    logic swapCompleteFlag_q, swapCompleteFlag_d;
    resource_type resourceSelect_q, resourceSelect_d;
    logic [IRQ_W-1:0] irqStatus_q, irqStatus_d;
    logic [IRQ_W-1:0] irqMask_q, irqMask_d;
    logic [31:0] prdata_q, prdata_d;

    // Engine and resource wiring
    logic engineStart;
    logic engineBusy;
    logic engineDone;
    logic engineMatched;
    logic [31:0] engineOld;
    resource_type bankSel;
    logic [31:0] bankRdData;
    logic bankWrEn;
    logic [31:0] bankWrData;
    logic [IRQ_W-1:0] irqEvents;
    resource_type writeSel;

    function automatic logic addrMapped(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (addr)
            SWAP_DATA_OFFSET,
            SWAP_COMPARE_OFFSET,
            SWAP_CONTROL_OFFSET,
            IRQ_STATUS_OFFSET,
            IRQ_MASK_OFFSET,
            SWAP_STATE_OFFSET: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [31:0] controlWord(input logic done, input resource_type sel);
        logic [31:0] word;
        word = 32'h0000_0000;
        word[DONE_BIT] = done;
        word[SEL_LSB +: SEL_W] = sel;
        return word;
    endfunction

    // APB handshake: zero wait states, error on unmapped offsets
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign writeAccess = accessPhase && pwrite;
    assign pready = 1'b1;
    assign pslverr = accessPhase && !addrMapped(paddr);
    assign prdata = prdata_q;

    // Strobes fire in the access phase, the only edge at which a write lands
    assign wrData = writeAccess && (paddr == SWAP_DATA_OFFSET);
    assign wrCompare = writeAccess && (paddr == SWAP_COMPARE_OFFSET);
    assign wrControl = writeAccess && (paddr == SWAP_CONTROL_OFFSET);
    assign wrIrqStatus = writeAccess && (paddr == IRQ_STATUS_OFFSET);
    assign wrIrqMask = writeAccess && (paddr == IRQ_MASK_OFFSET);

    // A start during a running swap is dropped to keep each swap atomic
    assign engineStart = wrControl && !engineBusy;

    // Select field as written; feeds both the engine and the readback copy
    assign writeSel = resource_type'(pwdata[SEL_LSB +: SEL_W]);

    compare_swap_engine u_compare_swap_engine (
        .mclk(mclk),
        .nrst(nrst),
        .start(engineStart),
        .selIn(writeSel),
        .compareIn(swapCompare_q),
        .swapIn(swapData_q),
        .resSel(bankSel),
        .resRdData(bankRdData),
        .resWrEn(bankWrEn),
        .resWrData(bankWrData),
        .busy(engineBusy),
        .donePulse(engineDone),
        .matched(engineMatched),
        .oldValue(engineOld)
    );

    // Resources have no other host path than the engine
    csr_resource_bank u_csr_resource_bank (
        .mclk(mclk),
        .nrst(nrst),
        .sel(bankSel),
        .rdData(bankRdData),
        .wrEn(bankWrEn),
        .wrData(bankWrData)
    );

    // Swap data word
    always_comb begin
        swapData_d = swapData_q;
        if (wrData) begin
            swapData_d = pwdata;
        end
        if (engineDone) begin
            // Returns the prior resource value so software can judge the outcome
            // Engine result beats a host write landing in the same cycle
            swapData_d = engineOld;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            swapData_q <= SWAP_WORD_RESET;
        end else begin
            swapData_q <= swapData_d;
        end
    end

    // Compare word, never touched by the engine
    always_comb begin
        swapCompare_d = swapCompare_q;
        if (wrCompare) begin
            swapCompare_d = pwdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            swapCompare_q <= SWAP_WORD_RESET;
        end else begin
            swapCompare_q <= swapCompare_d;
        end
    end

    // Control register: completion flag
    always_comb begin
        swapCompleteFlag_d = swapCompleteFlag_q;
        if (wrControl) begin
            swapCompleteFlag_d = 1'b0;
        end
        // Completion wins over a clearing write in the same cycle
        if (engineDone) begin
            swapCompleteFlag_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            swapCompleteFlag_q <= CONTROL_RESET[DONE_BIT];
        end else begin
            swapCompleteFlag_q <= swapCompleteFlag_d;
        end
    end

    // Control register: resource select, kept while a swap runs so it shows the live target
    always_comb begin
        resourceSelect_d = resourceSelect_q;
        if (engineStart) begin
            resourceSelect_d = writeSel;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            resourceSelect_q <= resource_type'(CONTROL_RESET[SEL_LSB +: SEL_W]);
        end else begin
            resourceSelect_q <= resourceSelect_d;
        end
    end

    // Interrupt status, mask and output
    always_comb begin
        irqEvents = '0;
        irqEvents[IRQ_DONE_BIT] = engineDone;
        irqEvents[IRQ_MISS_BIT] = engineDone && !engineMatched;
        irqStatus_d = irqStatus_q;
        if (wrIrqStatus) begin
            irqStatus_d = irqStatus_q & ~pwdata[IRQ_W-1:0];
        end
        // Event set applied last so it beats a write-one-to-clear
        irqStatus_d = irqStatus_d | irqEvents;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irqStatus_q <= IRQ_RESET;
        end else begin
            irqStatus_q <= irqStatus_d;
        end
    end

    // Interrupt mask, plain read-write
    always_comb begin
        irqMask_d = irqMask_q;
        if (wrIrqMask) begin
            irqMask_d = pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irqMask_q <= IRQ_RESET;
        end else begin
            irqMask_q <= irqMask_d;
        end
    end

    assign irq = |(irqStatus_q & irqMask_q);

    // Read data captured in the setup phase, presented in the access phase
    always_comb begin
        prdata_d = prdata_q;
        if (setupPhase && !pwrite) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                SWAP_DATA_OFFSET: prdata_d = swapData_q;
                SWAP_COMPARE_OFFSET: prdata_d = swapCompare_q;
                SWAP_CONTROL_OFFSET: prdata_d = controlWord(swapCompleteFlag_q, resourceSelect_q);
                IRQ_STATUS_OFFSET: prdata_d[IRQ_W-1:0] = irqStatus_q;
                IRQ_MASK_OFFSET: prdata_d[IRQ_W-1:0] = irqMask_q;
                SWAP_STATE_OFFSET: begin
                    prdata_d[STATE_BUSY_BIT] = engineBusy;
                    prdata_d[STATE_MATCH_BIT] = engineMatched;
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

endmodule
`default_nettype wire

//--- verilog/bus_mgmt_csr_pkg.sv
// Shared constants and types for the bus-management compare-swap register group
package bus_mgmt_csr_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] SWAP_DATA_OFFSET = 8'h0C;
    localparam logic [7:0] SWAP_COMPARE_OFFSET = 8'h10;
    localparam logic [7:0] SWAP_CONTROL_OFFSET = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h40;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h44;
    localparam logic [7:0] SWAP_STATE_OFFSET = 8'h48;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Control register layout
    localparam int DONE_BIT = 31;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam logic [31:0] CONTROL_RESET = 32'h8000_0000;

    // Interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_MISS_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Engine state register layout
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_MATCH_BIT = 1;

    // Data and compare registers come up cleared
    localparam logic [31:0] SWAP_WORD_RESET = 32'h0000_0000;

    // Power-on contents of the four resources
    localparam logic [31:0] BUS_MANAGER_ID_RESET = 32'h0000_003F;
    localparam logic [31:0] BANDWIDTH_RESET = 32'h0000_1333;
    localparam logic [31:0] CHANNELS_HI_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] CHANNELS_LO_RESET = 32'hFFFF_FFFF;

    localparam int RESOURCE_COUNT = 4;

    typedef enum logic [1:0] {
        BUS_MANAGER_ID = 2'h0,
        BANDWIDTH_AVAILABLE = 2'h1,
        CHANNELS_AVAILABLE_HI = 2'h2,
        CHANNELS_AVAILABLE_LO = 2'h3
    } resource_type;

    typedef enum logic [2:0] {
        SWAP_IDLE = 3'h1,
        SWAP_FETCH = 3'h2,
        SWAP_FINISH = 3'h4
    } swap_state_type;

endpackage

//--- verilog/csr_resource_bank.sv
// Storage for the four bus-management resources
`timescale 1ns/1ps
`default_nettype none

module csr_resource_bank (
    input wire logic mclk,
    input wire logic nrst,
    input wire bus_mgmt_csr_pkg::resource_type sel,
    output logic [31:0] rdData,
    input wire logic wrEn,
    input wire logic [31:0] wrData
);
    import bus_mgmt_csr_pkg::*;

    logic [31:0] resource_q [RESOURCE_COUNT];
    logic [31:0] resource_d [RESOURCE_COUNT];

    function automatic logic [31:0] resetValue(input int idx);
        logic [31:0] val;
        unique case (idx)
            0: val = BUS_MANAGER_ID_RESET;
            1: val = BANDWIDTH_RESET;
            2: val = CHANNELS_HI_RESET;
            default: val = CHANNELS_LO_RESET;
        endcase
        return val;
    endfunction

    assign rdData = resource_q[sel];

    always_comb begin
        for (int i = 0; i < RESOURCE_COUNT; i++) begin
            resource_d[i] = resource_q[i];
        end
        if (wrEn) begin
            resource_d[sel] = wrData;
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < RESOURCE_COUNT; i++) begin
            if (!nrst) begin
                resource_q[i] <= resetValue(i);
            end else begin
                resource_q[i] <= resource_d[i];
            end
        end
    end

endmodule
`default_nettype wire

//--- verilog/compare_swap_engine.sv
// Sequencer for one atomic compare-swap on a selected resource
`timescale 1ns/1ps
`default_nettype none

module compare_swap_engine (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire bus_mgmt_csr_pkg::resource_type selIn,
    input wire logic [31:0] compareIn,
    input wire logic [31:0] swapIn,
    output bus_mgmt_csr_pkg::resource_type resSel,
    input wire logic [31:0] resRdData,
    output logic resWrEn,
    output logic [31:0] resWrData,
    output logic busy,
    output logic donePulse,
    output logic matched,
    output logic [31:0] oldValue
);
    import bus_mgmt_csr_pkg::*;

    swap_state_type state_q, state_d;
    resource_type sel_q, sel_d;
    logic [31:0] compare_q, compare_d;
    logic [31:0] swap_q, swap_d;
    logic [31:0] old_q, old_d;
    logic match_q, match_d;

    assign resSel = sel_q;
    assign busy = (state_q != SWAP_IDLE);
    assign donePulse = (state_q == SWAP_FINISH);
    assign matched = match_q;
    assign oldValue = old_q;
    assign resWrData = swap_q;
    // Read, compare and write land in one cycle, so nothing can slip between
    assign resWrEn = (state_q == SWAP_FETCH) && (resRdData == compare_q);

    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        compare_d = compare_q;
        swap_d = swap_q;
        old_d = old_q;
        match_d = match_q;
        unique case (state_q)
            SWAP_IDLE: begin
                if (start) begin
                    // Operands frozen here; later register writes do not disturb the swap
                    sel_d = selIn;
                    compare_d = compareIn;
                    swap_d = swapIn;
                    state_d = SWAP_FETCH;
                end
            end
            SWAP_FETCH: begin
                old_d = resRdData;
                match_d = (resRdData == compare_q);
                state_d = SWAP_FINISH;
            end
            SWAP_FINISH: begin
                state_d = SWAP_IDLE;
            end
            default: begin
                state_d = SWAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q <= SWAP_IDLE;
            sel_q <= BUS_MANAGER_ID;
            compare_q <= SWAP_WORD_RESET;
            swap_q <= SWAP_WORD_RESET;
            old_q <= SWAP_WORD_RESET;
            match_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            compare_q <= compare_d;
            swap_q <= swap_d;
            old_q <= old_d;
            match_q <= match_d;
        end
    end

endmodule
`default_nettype wire

//--- testbench/bus_mgmt_csr_sva.sv
// Concurrent checks on the compare-swap register group ports
`timescale 1ns/1ps
`default_nettype none

module bus_mgmt_csr_sva
    import bus_mgmt_csr_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic acc = psel && penable;
    wire logic mapped = paddr inside {SWAP_DATA_OFFSET, SWAP_COMPARE_OFFSET, SWAP_CONTROL_OFFSET,
        IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET, SWAP_STATE_OFFSET};
    wire logic ctrlWr = acc && pwrite && paddr == SWAP_CONTROL_OFFSET;
    wire logic ctrlRdSetup = psel && !penable && !pwrite && paddr == SWAP_CONTROL_OFFSET;
    wire logic dataWr = acc && pwrite && paddr == SWAP_DATA_OFFSET;
    wire logic dataRdSetup = psel && !penable && !pwrite && paddr == SWAP_DATA_OFFSET;
    sequence s_ctrl_wr;
        ctrlWr;
    endsequence
    sequence s_quiet4;
        (!ctrlWr)[*4];
    endsequence
    property p_ready;
        acc |-> pready;
    endproperty
    property p_unmapped;
        acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    property p_mapped;
        acc && mapped |-> !pslverr;
    endproperty
    property p_reserved;
        acc && !pwrite && paddr == SWAP_CONTROL_OFFSET |-> prdata[30:2] == 29'h0;
    endproperty
    property p_done_clear;
        s_ctrl_wr ##2 ctrlRdSetup |=> !prdata[31];
    endproperty
    property p_done_set;
        s_ctrl_wr ##1 s_quiet4 ##1 ctrlRdSetup |=> prdata[31];
    endproperty
    property p_data_rdback;
        dataWr ##2 dataRdSetup |=> prdata == $past(pwdata, 3);
    endproperty
    property p_irq_reset;
        $rose(nrst) |-> !irq;
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready low in access phase");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    a_mapped: assert property (p_mapped)
        else $error("error on mapped register");
    a_reserved: assert property (p_reserved)
        else $error("reserved control bits not zero");
    a_done_clear: assert property (p_done_clear)
        else $error("done flag not cleared by control write");
    a_done_set: assert property (p_done_set)
        else $error("done flag not set after swap");
    a_data_rdback: assert property (p_data_rdback)
        else $error("swap data readback wrong");
    a_irq_reset: assert property (p_irq_reset)
        else $error("interrupt high after reset");
endmodule

bind bus_mgmt_swap_compare_value_swap bus_mgmt_csr_sva u_bus_mgmt_csr_sva (.mclk(mclk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

//--- testbench/bus_mgmt_swap_compare_value_swap_tb.sv
// Self-checking bench for the compare-swap register group
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module bus_mgmt_swap_compare_value_swap_tb;
    import bus_mgmt_csr_pkg::*;
    typedef struct {logic [1:0] sel; logic [31:0] cmpV; logic [31:0] swp; logic [31:0] old; logic miss;} row_type;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_fail = 0;
    int cmp_count = 0;
    // Rows run in order: later rows see what earlier swaps left behind
    row_type rows[9] = '{
        '{2'h0, 32'h0000_003F, 32'h0000_0005, 32'h0000_003F, 1'b0},
        '{2'h1, 32'h0000_0000, 32'h0000_0100, 32'h0000_1333, 1'b1},
        '{2'h2, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF, 1'b0},
        '{2'h3, 32'h0000_0001, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1},
        '{2'h0, 32'h0000_0005, 32'h0000_0005, 32'h0000_0005, 1'b0},
        '{2'h1, 32'h0000_1333, 32'h0000_0200, 32'h0000_1333, 1'b0},
        '{2'h2, 32'h0000_0000, 32'h0000_0001, 32'h0000_FFFF, 1'b1},
        '{2'h3, 32'hFFFF_FFFF, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0},
        '{2'h1, 32'h0000_0200, 32'h0000_0200, 32'h0000_0200, 1'b0}};

    bus_mgmt_swap_compare_value_swap u_bus_mgmt_swap_compare_value_swap (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One APB transfer; answer taken at the edge where pready is seen high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_done;
        for (int k = 0; k < 10; k++) begin
            apb(1'b0, SWAP_CONTROL_OFFSET, 32'h0);
            if (rd[31] === 1'b1) break;
        end
        `CHK(rd[31], 1'b1)
        if (rd[31] !== 1'b1) conclude();
    endtask

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        apb(1'b1, IRQ_MASK_OFFSET, 32'h3);
        foreach (rows[i]) begin
            apb(1'b1, SWAP_COMPARE_OFFSET, rows[i].cmpV);
            apb(1'b1, SWAP_DATA_OFFSET, rows[i].swp);
            apb(1'b0, SWAP_DATA_OFFSET, 32'h0);
            `CHK(rd, rows[i].swp)
            apb(1'b1, SWAP_CONTROL_OFFSET, {30'h0, rows[i].sel});
            wait_done();
            `CHK(irq, 1'b1)
            apb(1'b0, SWAP_DATA_OFFSET, 32'h0);
            `CHK(rd, rows[i].old)
            apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
            `CHK(rd, {30'h0, rows[i].miss, 1'b1})
            apb(1'b1, IRQ_STATUS_OFFSET, 32'h3);
            // Status clears at the write's edge; look once it has settled
            @(negedge mclk);
            `CHK(irq, 1'b0)
            $display("row %0d finished", i);
        end
        // Second reset mid-run must restore the control, compare and irq mask registers and the bus manager resource
        nrst <= 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        apb(1'b0, SWAP_CONTROL_OFFSET, 32'h0);
        `CHK(rd, CONTROL_RESET)
        apb(1'b0, SWAP_COMPARE_OFFSET, 32'h0);
        `CHK(rd, SWAP_WORD_RESET)
        apb(1'b1, SWAP_COMPARE_OFFSET, BUS_MANAGER_ID_RESET);
        apb(1'b1, SWAP_CONTROL_OFFSET, 32'h0);
        wait_done();
        `CHK(irq, 1'b0)
        apb(1'b0, SWAP_DATA_OFFSET, 32'h0);
        `CHK(rd, BUS_MANAGER_ID_RESET)
        apb(1'b0, SWAP_STATE_OFFSET, 32'h0);
        `CHK(rd, (32'h1 << STATE_MATCH_BIT))
        $display("reset test finished");
        // Writing ones to done and reserved bits must still clear and hide them
        apb(1'b1, SWAP_CONTROL_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, SWAP_CONTROL_OFFSET, 32'h0);
        `CHK(rd, 32'h0000_0003)
        wait_done();
        apb(1'b0, SWAP_STATE_OFFSET, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, 8'h30, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h30, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        $display("awkward tests finished");
        conclude();
    end
endmodule
`default_nettype wire
